// ---- logic/dhti_core.sv ----
// Host task port, command engine and sector buffer of the disk controller
// Operation
// - Restore scans ID, else steps out, 2047 limit
// - Long mode skips the ECC check
// - Retry bit one disables ECC correction
// - Seek to task cylinder, interrupt on completion
// - Read/write 1..256 sectors with implied seek
// - Read corrects, flags bad sector, interrupts each
// - Write: first buffer without interrupt, later with
// - Multi-sector crosses track and cylinder boundaries
// - Format track from buffer, zero data, interrupt
// - Verify reads and checks, no host data
// - Diagnose puts result code in error register
// - Set parameters stores sectors and heads per drive
// - Step code decodes to documented intervals
// - Default step interval is 6.50 ms
// - Alternate status layout, live and latched bits
// - Index bit follows selected drive index live
// - Error sectors leave sector number on that sector; corrected sectors go on and advance it
// - Line monitor shows inverted gate, head, select
// - Soft reset bit holds disk logic reset
// - Interrupt disable masks, keeps pending, starts set
// - Data port words, latched then stored
// - Reads return staged word and prefetch next
// - Reject busy, abort on drive faults, bad codes
// - Command, soft or master reset clears interrupt
`timescale 1ns/1ns
module dhti_core #(
  parameter int P_WORDS = dhti_pkg::SECT_WORDS,
  parameter int P_STEP_UNIT_CYC = dhti_pkg::STEP_UNIT_CYC,
  parameter int P_TMR_W = 18
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Host I/O bus
  input wire logic [9:0] i_io_addr,
  input wire logic i_io_rd_n,
  input wire logic i_io_wr_n,
  input wire logic [15:0] i_io_data,
  output logic [15:0] o_io_data,
  output logic o_io_data_oe_n,
  output logic o_irq,
  // Drive control lines
  input wire logic i_drv_index,
  input wire logic i_drv_ready,
  input wire logic i_drv_seek_done,
  input wire logic i_drv_track0,
  input wire logic i_drv_wfault,
  output logic o_drv_step,
  output logic o_drv_dir_in,
  output logic [1:0] o_drv_sel,
  output logic [3:0] o_drv_head,
  output logic o_drv_wgate,
  // Disk data side
  input wire logic i_dsk_id_ok,
  input wire logic i_dsk_stb,
  input wire logic [15:0] i_dsk_word,
  input wire logic i_dsk_ecc_bad,
  input wire logic i_dsk_ecc_fixed,
  output logic [15:0] o_dsk_word,
  output logic o_dsk_read,
  output logic o_dsk_write
);
  localparam int AW = $clog2(P_WORDS);
  localparam logic [AW:0] LAST = (AW + 1)'(P_WORDS - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(P_WORDS);
  localparam logic [P_TMR_W-1:0] PW = P_TMR_W'(dhti_pkg::STEP_PW_CYC);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEEK = 4'h2,
    ST_DISK = 4'h4,
    ST_HOST = 4'h8
  } dhti_st_t;

  typedef struct packed {
    logic [2:0] rd_s;
    logic [2:0] wr_s;
    logic [9:0] a1;
    logic [9:0] a2;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [4:0] ln1;
    logic [4:0] ln2;
    dhti_st_t st;
    logic start;
    logic bsy;
    logic data_request_flag;
    logic irq;
    logic write_fault_flag;
    logic seek_done_flag;
    logic corrected_data_flag;
    logic err;
    logic [7:0] erreg;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [15:0] cyl;
    logic [7:0] size_drive_head_register_short;
    logic [7:0] cmd;
    logic [7:0] aux;
    logic [3:0] rate;
    logic [15:0] cur;
    logic [15:0] tgt;
    logic rst_mode;
    logic [10:0] steps;
    logic [P_TMR_W-1:0] tmr;
    logic [1:0][7:0] spt;
    logic [1:0][3:0] mh;
    logic [3:0] head;
    logic [1:0] sel;
    logic [8:0] left;
    logic [AW:0] hptr;
    logic pw;
    logic [15:0] wlat;
    logic [15:0] stage;
    logic [15:0] rdata;
    logic oe_n;
    logic [AW:0] dptr;
    logic [15:0] dword;
    logic step;
    logic dir;
    logic wgate;
  } dhti_state_t;

  dhti_state_t s_q, s_d;
  logic [15:0] buf_q [0:P_WORDS-1];
  logic rd_p, wr_p, cmd_ok, dsk_wr;
  logic lv_idx, lv_rdy, lv_skc, lv_tk0, lv_wf;
  logic [2:0] cls;
  logic [7:0] status;

  function automatic logic [2:0] dhti_class(input logic [7:0] c);
    if (c[7:4] == 4'h1) return dhti_pkg::C_RESTORE;
    if (c[7:4] == 4'h7) return dhti_pkg::C_SEEK;
    if (c[7:2] == 6'h08) return dhti_pkg::C_READ;
    if (c[7:2] == 6'h0C) return dhti_pkg::C_WRITE;
    if (c == 8'h50) return dhti_pkg::C_FORMAT;
    if (c[7:1] == 7'h20) return dhti_pkg::C_VERIFY;
    if (c == 8'h90 || c == dhti_pkg::OP_SETPARAM) return dhti_pkg::C_DIAG;
    return dhti_pkg::C_BAD;
  endfunction : dhti_class

  function automatic logic [P_TMR_W-1:0] dhti_step_cyc(input logic [3:0] c);
    int v;
    v = int'(c) * P_STEP_UNIT_CYC;
    if (c == 4'h0) v = dhti_pkg::STEP0_CYC;
    if (c == 4'hE) v = dhti_pkg::STEPE_CYC;
    if (c == 4'hF) v = dhti_pkg::STEPF_CYC;
    return P_TMR_W'(v);
  endfunction : dhti_step_cyc

  // Next sector, head and cylinder in sequence
  function automatic logic [27:0] dhti_next(input logic [7:0] sn, input logic [3:0] hd,
                                            input logic [15:0] cy, input logic [7:0] spt,
                                            input logic [3:0] mh);
    if (sn < spt) return {cy, hd, sn + 8'h01};
    if (hd < mh) return {cy, hd + 4'h1, 8'h01};
    return {cy + 16'h0001, 4'h0, 8'h01};
  endfunction : dhti_next

  assign rd_p = s_q.rd_s[1] & ~s_q.rd_s[2];
  assign wr_p = s_q.wr_s[1] & ~s_q.wr_s[2];
  assign {lv_idx, lv_rdy, lv_skc, lv_tk0, lv_wf} = s_q.ln2;
  assign cls = dhti_class(s_q.cmd);
  assign cmd_ok = wr_p && s_q.a2 == dhti_pkg::ADR_CMD && s_q.st == ST_IDLE;
  assign dsk_wr = s_q.st == ST_DISK && i_dsk_stb && (cls == dhti_pkg::C_READ || cls == dhti_pkg::C_VERIFY);
  // Live bits sampled now, the rest latched per sector
  assign status = {s_q.bsy, lv_rdy, s_q.write_fault_flag, s_q.seek_done_flag, s_q.data_request_flag, s_q.corrected_data_flag, lv_idx, s_q.err};

  always_comb begin
    logic [27:0] nx;
    logic drv;
    logic bad;
    logic fixed;
    logic done;
    nx = '0;
    drv = s_q.size_drive_head_register_short[dhti_pkg::SDH_DRV_BIT];
    bad = 1'b0;
    fixed = 1'b0;
    done = 1'b0;
    s_d = s_q;
    s_d.rd_s = {s_q.rd_s[1:0], ~i_io_rd_n};
    s_d.wr_s = {s_q.wr_s[1:0], ~i_io_wr_n};
    s_d.a1 = i_io_addr;
    s_d.a2 = s_q.a1;
    s_d.d1 = i_io_data;
    s_d.d2 = s_q.d1;
    s_d.ln1 = {i_drv_index, i_drv_ready, i_drv_seek_done, i_drv_track0, i_drv_wfault};
    s_d.ln2 = s_q.ln1;
    s_d.oe_n = ~(s_q.rd_s[1] && (s_q.a2[9:3] == 7'h3E || s_q.a2 == dhti_pkg::ADR_ASR
                 || s_q.a2 == dhti_pkg::ADR_DLM));
    s_d.pw = 1'b0;
    if (s_q.pw) begin
      s_d.hptr = s_q.hptr + 1'b1;
      if (s_q.hptr == LAST) s_d.data_request_flag = 1'b0;
    end
    // Host writes
    if (wr_p) begin
      unique case (s_q.a2)
        dhti_pkg::ADR_DATA: begin
          if (s_q.data_request_flag && s_q.st == ST_HOST && cls != dhti_pkg::C_READ) begin
            s_d.wlat = s_q.d2;
            s_d.pw = 1'b1;
          end
        end
        dhti_pkg::ADR_SCNT: if (!s_q.bsy) s_d.scnt = s_q.d2[7:0];
        dhti_pkg::ADR_SNUM: if (!s_q.bsy) s_d.snum = s_q.d2[7:0];
        dhti_pkg::ADR_CYLL: if (!s_q.bsy) s_d.cyl[7:0] = s_q.d2[7:0];
        dhti_pkg::ADR_CYLH: if (!s_q.bsy) s_d.cyl[15:8] = s_q.d2[7:0];
        dhti_pkg::ADR_SDH: if (!s_q.bsy) s_d.size_drive_head_register_short = s_q.d2[7:0];
        dhti_pkg::ADR_CMD: begin
          if (s_q.st == ST_IDLE) begin
            s_d.cmd = s_q.d2[7:0];
            s_d.start = 1'b1;
            s_d.irq = 1'b0;
          end
        end
        dhti_pkg::ADR_ASR: s_d.aux = s_q.d2[7:0];
        default: ;
      endcase
    end
    // Host reads
    if (rd_p) begin
      unique case (s_q.a2)
        dhti_pkg::ADR_DATA: begin
          s_d.rdata = s_q.stage;
          if (s_q.data_request_flag && s_q.st == ST_HOST && cls == dhti_pkg::C_READ) begin
            s_d.stage = buf_q[s_q.hptr[AW-1:0]];
            s_d.hptr = s_q.hptr + 1'b1;
            if (s_q.hptr == FULL) s_d.data_request_flag = 1'b0;
          end
        end
        dhti_pkg::ADR_ERR: s_d.rdata = {8'h00, s_q.erreg};
        dhti_pkg::ADR_SCNT: s_d.rdata = {8'h00, s_q.scnt};
        dhti_pkg::ADR_SNUM: s_d.rdata = {8'h00, s_q.snum};
        dhti_pkg::ADR_CYLL: s_d.rdata = {8'h00, s_q.cyl[7:0]};
        dhti_pkg::ADR_CYLH: s_d.rdata = {8'h00, s_q.cyl[15:8]};
        dhti_pkg::ADR_SDH: s_d.rdata = {8'h00, s_q.size_drive_head_register_short};
        dhti_pkg::ADR_CMD: begin
          s_d.rdata = {8'h00, status};
          s_d.irq = 1'b0;
        end
        dhti_pkg::ADR_ASR: s_d.rdata = {8'h00, status};
        dhti_pkg::ADR_DLM: s_d.rdata = {8'h00, 1'b0, ~s_q.wgate, ~s_q.head, ~s_q.sel};
        default: ;
      endcase
    end
    // Step pulse and interval timer
    if (s_q.tmr != '0) s_d.tmr = (s_q.tmr == dhti_step_cyc(s_q.rate)) ? '0 : s_q.tmr + 1'b1;
    s_d.wgate = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (s_q.start) begin
          s_d.start = 1'b0;
          s_d.bsy = 1'b1;
          s_d.err = 1'b0;
          s_d.corrected_data_flag = 1'b0;
          s_d.write_fault_flag = 1'b0;
          s_d.erreg = 8'h00;
          s_d.sel = drv ? 2'b10 : 2'b01;
          s_d.head = s_q.size_drive_head_register_short[3:0];
          s_d.left = (s_q.scnt == 8'h00) ? dhti_pkg::SCNT_ZERO : {1'b0, s_q.scnt};
          s_d.tgt = s_q.cyl;
          if (cls == dhti_pkg::C_BAD) begin
            s_d.erreg[dhti_pkg::ERR_ABT_BIT] = 1'b1;
            done = 1'b1;
          end else if (s_q.cmd == dhti_pkg::OP_SETPARAM) begin
            s_d.spt[drv] = s_q.scnt;
            s_d.mh[drv] = s_q.size_drive_head_register_short[3:0];
            done = 1'b1;
          end else if (cls == dhti_pkg::C_DIAG) begin
            s_d.erreg = dhti_pkg::DIAG_PASS;
            done = 1'b1;
          end else if (!lv_rdy || !lv_skc || lv_wf) begin
            s_d.erreg[dhti_pkg::ERR_ABT_BIT] = 1'b1;
            s_d.write_fault_flag = lv_wf;
            done = 1'b1;
          end else if (cls == dhti_pkg::C_WRITE || cls == dhti_pkg::C_FORMAT) begin
            s_d.st = ST_HOST;
            s_d.data_request_flag = 1'b1;
            s_d.bsy = 1'b0;
            s_d.hptr = '0;
          end else begin
            s_d.st = ST_SEEK;
            s_d.seek_done_flag = 1'b0;
            if (cls == dhti_pkg::C_RESTORE || cls == dhti_pkg::C_SEEK) s_d.rate = s_q.cmd[3:0];
            if (cls == dhti_pkg::C_RESTORE) begin
              s_d.tgt = 16'h0000;
              s_d.rst_mode = ~i_dsk_id_ok;
              s_d.steps = '0;
            end
          end
        end
      end
      ST_SEEK: begin
        if (s_q.tmr == '0) begin
          if (s_q.rst_mode) begin
            if (lv_tk0 && lv_skc) begin
              s_d.cur = 16'h0000;
              s_d.rst_mode = 1'b0;
            end else if (s_q.steps == dhti_pkg::RESTORE_MAX) begin
              s_d.erreg[dhti_pkg::ERR_TK0_BIT] = 1'b1;
              s_d.rst_mode = 1'b0;
              done = 1'b1;
            end else if (lv_skc) begin
              s_d.dir = 1'b0;
              s_d.steps = s_q.steps + 1'b1;
              s_d.tmr = P_TMR_W'(1);
            end
          end else if (s_q.cur != s_q.tgt) begin
            s_d.dir = s_q.tgt > s_q.cur;
            s_d.cur = (s_q.tgt > s_q.cur) ? s_q.cur + 16'h0001 : s_q.cur - 16'h0001;
            s_d.tmr = P_TMR_W'(1);
          end else if (lv_skc) begin
            s_d.seek_done_flag = 1'b1;
            if (cls == dhti_pkg::C_RESTORE || cls == dhti_pkg::C_SEEK) begin
              done = 1'b1;
            end else begin
              s_d.st = ST_DISK;
              s_d.dptr = '0;
              s_d.dword = (cls == dhti_pkg::C_FORMAT) ? 16'h0000 : buf_q[0];
            end
          end
        end
      end
      ST_DISK: begin
        if (cls == dhti_pkg::C_WRITE || cls == dhti_pkg::C_FORMAT) begin
          s_d.wgate = ~lv_wf;
          if (lv_wf) begin
            s_d.write_fault_flag = 1'b1;
            s_d.err = 1'b1;
            done = 1'b1;
          end
        end
        if (i_dsk_stb && !done) begin
          s_d.dptr = s_q.dptr + 1'b1;
          // Format data fields go out as zeros
          s_d.dword = (cls == dhti_pkg::C_FORMAT) ? 16'h0000 : buf_q[AW'(s_q.dptr + 1'b1)];
          if (s_q.dptr == LAST) begin
            bad = i_dsk_ecc_bad & ~s_q.cmd[dhti_pkg::CMD_LONG_BIT];
            fixed = bad & i_dsk_ecc_fixed & ~s_q.cmd[dhti_pkg::CMD_RTY_BIT];
            nx = dhti_next(s_q.snum, s_q.head, s_q.cur, s_q.spt[drv], s_q.mh[drv]);
            if (fixed) s_d.corrected_data_flag = 1'b1;
            if (bad && !fixed) begin
              s_d.erreg[dhti_pkg::ERR_ECC_BIT] = 1'b1;
              s_d.err = 1'b1;
            end
            if (cls == dhti_pkg::C_READ) begin
              s_d.st = ST_HOST;
              s_d.data_request_flag = 1'b1;
              s_d.irq = 1'b1;
              s_d.bsy = 1'b0;
              s_d.hptr = (AW + 1)'(1);
              s_d.stage = buf_q[0];
            end else if (cls == dhti_pkg::C_FORMAT || s_q.left == 9'h001 || (bad && !fixed)) begin
              done = 1'b1;
            end else begin
              s_d.left = s_q.left - 9'h001;
              {s_d.cyl, s_d.head, s_d.snum} = nx;
              s_d.size_drive_head_register_short[3:0] = nx[11:8];
              s_d.tgt = nx[27:12];
              if (cls == dhti_pkg::C_WRITE) begin
                s_d.st = ST_HOST;
                s_d.data_request_flag = 1'b1;
                s_d.irq = 1'b1;
                s_d.bsy = 1'b0;
                s_d.hptr = '0;
              end else begin
                s_d.st = ST_SEEK;
              end
            end
          end
        end
      end
      ST_HOST: begin
        if (!s_q.data_request_flag && !s_q.pw) begin
          s_d.bsy = 1'b1;
          nx = dhti_next(s_q.snum, s_q.head, s_q.cur, s_q.spt[drv], s_q.mh[drv]);
          if (cls != dhti_pkg::C_READ) begin
            s_d.st = ST_SEEK;
          end else if (s_q.err || s_q.left == 9'h001) begin
            s_d.bsy = 1'b0;
            s_d.st = ST_IDLE;
          end else begin
            s_d.left = s_q.left - 9'h001;
            {s_d.cyl, s_d.head, s_d.snum} = nx;
            s_d.size_drive_head_register_short[3:0] = nx[11:8];
            s_d.tgt = nx[27:12];
            s_d.st = ST_SEEK;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (done) begin
      if (s_d.erreg[7:2] != 6'h00 || s_d.erreg[dhti_pkg::ERR_TK0_BIT]) s_d.err = cls != dhti_pkg::C_DIAG;
      s_d.bsy = 1'b0;
      s_d.irq = 1'b1;
      s_d.st = ST_IDLE;
    end
    s_d.step = (s_d.tmr != '0) && (s_d.tmr <= PW);
    // Soft reset holds the disk side; the host path stays alive
    if (s_q.aux[dhti_pkg::AUX_RST_BIT]) begin
      s_d.st = ST_IDLE;
      s_d.start = 1'b0;
      s_d.bsy = 1'b0;
      s_d.data_request_flag = 1'b0;
      s_d.irq = 1'b0;
      s_d.err = 1'b0;
      s_d.erreg = dhti_pkg::DIAG_PASS;
      s_d.rate = dhti_pkg::RATE_RESET;
      s_d.rst_mode = 1'b0;
      s_d.tmr = '0;
      s_d.step = 1'b0;
      s_d.sel = 2'b00;
      s_d.pw = 1'b0;
      s_d.wgate = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.aux <= dhti_pkg::AUX_RESET;
      s_q.rate <= dhti_pkg::RATE_RESET;
      s_q.erreg <= dhti_pkg::DIAG_PASS;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Buffer has no reset; contents are undefined until filled
  always_ff @(posedge i_core_clk) begin
    if (s_q.pw) begin
      buf_q[s_q.hptr[AW-1:0]] <= s_q.wlat;
    end else if (dsk_wr) begin
      buf_q[s_q.dptr[AW-1:0]] <= i_dsk_word;
    end
  end

  assign o_io_data = s_q.rdata;
  assign o_io_data_oe_n = s_q.oe_n;
  assign o_irq = s_q.irq & ~s_q.aux[dhti_pkg::AUX_IDS_BIT] & ~s_q.bsy;
  assign o_drv_step = s_q.step;
  assign o_drv_dir_in = s_q.dir;
  assign o_drv_sel = s_q.sel;
  assign o_drv_head = s_q.head;
  assign o_drv_wgate = s_q.wgate;
  assign o_dsk_word = s_q.dword;
  assign o_dsk_read = s_q.st == ST_DISK && cls != dhti_pkg::C_WRITE && cls != dhti_pkg::C_FORMAT;
  assign o_dsk_write = s_q.st == ST_DISK && (cls == dhti_pkg::C_WRITE || cls == dhti_pkg::C_FORMAT);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_restore_limit: assert property (
    s_q.st == ST_SEEK && s_q.rst_mode && s_q.tmr == '0 && s_q.steps == dhti_pkg::RESTORE_MAX
    && !(lv_tk0 && lv_skc) && !s_q.aux[dhti_pkg::AUX_RST_BIT]
    |=> s_q.erreg[dhti_pkg::ERR_TK0_BIT] && s_q.err && s_q.st == ST_IDLE)
    else $error("restore did not abort at step limit");
  chk_irq_masked: assert property (
    o_irq |-> !s_q.aux[dhti_pkg::AUX_IDS_BIT] && s_q.irq)
    else $error("interrupt seen while disabled");
  chk_irq_kept: assert property (
    s_q.irq && s_q.aux[dhti_pkg::AUX_IDS_BIT] && !wr_p && !rd_p && s_q.st == ST_IDLE
    && !s_q.aux[dhti_pkg::AUX_RST_BIT] |=> s_q.irq)
    else $error("masked interrupt request lost");
  chk_cmd_clears: assert property (
    cmd_ok && !s_q.aux[dhti_pkg::AUX_RST_BIT] |=> !s_q.irq ##1 s_q.bsy || s_q.irq || s_q.data_request_flag)
    else $error("command did not clear interrupt");
  chk_busy_reject: assert property (
    wr_p && s_q.a2 == dhti_pkg::ADR_CMD && s_q.st != ST_IDLE |=> s_q.cmd == $past(s_q.cmd))
    else $error("command taken while busy");
  chk_srst_hold: assert property (
    s_q.aux[dhti_pkg::AUX_RST_BIT] [*2] |-> s_q.st == ST_IDLE && !o_drv_step && !o_irq)
    else $error("disk logic ran during soft reset");
  chk_post_write: assert property (
    s_q.pw |=> s_q.hptr == $past(s_q.hptr) + 1'b1 && buf_q[$past(s_q.hptr[AW-1:0])] == $past(s_q.wlat))
    else $error("posted word not stored");
  chk_prefetch: assert property (
    rd_p && s_q.a2 == dhti_pkg::ADR_DATA |=> o_io_data == $past(s_q.stage))
    else $error("data read did not return staged word");
  chk_index_live: assert property (
    rd_p && s_q.a2 == dhti_pkg::ADR_ASR |=> o_io_data[1] == $past(s_q.ln2[4]))
    else $error("index bit not live");
  chk_wfault_gate: assert property (
    lv_wf |=> !o_drv_wgate)
    else $error("write gate held under write fault");

  cov_restore: cover property (cmd_ok && s_q.d2[7:4] == 4'h1 ##[1:300] s_q.st == ST_SEEK);
  cov_read_data: cover property (s_q.st == ST_HOST && cls == dhti_pkg::C_READ && rd_p);
  cov_write_post: cover property (s_q.pw ##[1:20] s_q.pw);
  cov_corrected: cover property (s_q.corrected_data_flag && s_q.st == ST_SEEK);
endmodule : dhti_core

// ---- include/dhti_pkg.sv ----
// Constants for the disk host task interface
package dhti_pkg;
  // Host port addresses
  localparam logic [9:0] ADR_DATA = 10'h1F0;
  localparam logic [9:0] ADR_ERR = 10'h1F1;
  localparam logic [9:0] ADR_SCNT = 10'h1F2;
  localparam logic [9:0] ADR_SNUM = 10'h1F3;
  localparam logic [9:0] ADR_CYLL = 10'h1F4;
  localparam logic [9:0] ADR_CYLH = 10'h1F5;
  localparam logic [9:0] ADR_SDH = 10'h1F6;
  localparam logic [9:0] ADR_CMD = 10'h1F7;
  localparam logic [9:0] ADR_ASR = 10'h3F6;
  localparam logic [9:0] ADR_DLM = 10'h3F7;
  // Auxiliary control fields and reset value
  localparam int AUX_RST_BIT = 2;
  localparam int AUX_IDS_BIT = 1;
  localparam logic [7:0] AUX_RESET = 8'h02;
  // Error register fields
  localparam int ERR_ECC_BIT = 6;
  localparam int ERR_ABT_BIT = 2;
  localparam int ERR_TK0_BIT = 1;
  localparam logic [7:0] DIAG_PASS = 8'h01;
  // Command byte and SDH register fields
  localparam int CMD_LONG_BIT = 1;
  localparam int CMD_RTY_BIT = 0;
  localparam int SDH_DRV_BIT = 4;
  // Command classes
  localparam logic [2:0] C_RESTORE = 3'h0;
  localparam logic [2:0] C_SEEK = 3'h1;
  localparam logic [2:0] C_READ = 3'h2;
  localparam logic [2:0] C_WRITE = 3'h3;
  localparam logic [2:0] C_FORMAT = 3'h4;
  localparam logic [2:0] C_VERIFY = 3'h5;
  localparam logic [2:0] C_DIAG = 3'h6;
  localparam logic [2:0] C_BAD = 3'h7;
  localparam logic [7:0] OP_SETPARAM = 8'h91;
  // Stepping and sequencing
  localparam logic [3:0] RATE_RESET = 4'hD;
  localparam logic [10:0] RESTORE_MAX = 11'h7FF;
  localparam logic [8:0] SCNT_ZERO = 9'h100;
  localparam int SECT_WORDS = 256;
  // Timing
  localparam int CLK_NS = 40;
  localparam int STEP_UNIT_NS = 500000;
  localparam int STEP0_NS = 35000;
  localparam int STEPE_NS = 3200;
  localparam int STEPF_NS = 16000;
  localparam int STEP_PW_NS = 1000;
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_NS;
  localparam int STEP0_CYC = STEP0_NS / CLK_NS;
  localparam int STEPE_CYC = STEPE_NS / CLK_NS;
  localparam int STEPF_CYC = STEPF_NS / CLK_NS;
  localparam int STEP_PW_CYC = (STEP_PW_NS + CLK_NS - 1) / CLK_NS;
endpackage : dhti_pkg

// ---- tb/dhti_host_model.sv ----
// Host processor model driving the controller I/O strobes
`timescale 1ns/1ns
module dhti_host_model (
  // Clock
  input wire logic i_core_clk,
  // Host I/O bus
  output logic [9:0] o_io_addr,
  output logic o_io_rd_n,
  output logic o_io_wr_n,
  output logic [15:0] o_io_data,
  input wire logic [15:0] i_io_data
);
  initial begin
    o_io_addr = 10'h000;
    o_io_rd_n = 1'b1;
    o_io_wr_n = 1'b1;
    o_io_data = 16'h0000;
  end
  // Strobe held 5 cycles, 4 idle after: the port syncs through two flops
  task automatic cycle(input logic [9:0] a, input logic wr, input logic [15:0] d, output logic [15:0] q);
    @(posedge i_core_clk);
    #2;
    o_io_addr = a;
    o_io_data = d;
    o_io_wr_n = ~wr;
    o_io_rd_n = wr;
    repeat (5) @(posedge i_core_clk);
    q = i_io_data;
    #2;
    o_io_wr_n = 1'b1;
    o_io_rd_n = 1'b1;
    o_io_data = ~d;
    repeat (4) @(posedge i_core_clk);
  endtask : cycle
endmodule : dhti_host_model

// ---- tb/dhti_core_bench.sv ----
// Self-checking bench for the disk host task core
`timescale 1ns/1ns
module dhti_core_bench;
  logic i_core_clk, i_resetn, idx, rdy, i_dsk_stb, io_rd_n, io_wr_n, o_irq, o_dsk_read;
  logic seek_done_flag, tk0, wf, id_ok, ecc_bad, ecc_fix, o_dsk_write, o_drv_wgate;
  logic [15:0] o_dsk_word;
  logic [9:0] io_addr;
  logic [15:0] io_wdata, o_io_data, i_dsk_word, q;
  int miscompares = 0;
  int checked = 0;
  int exp_q[$];

  dhti_core #(.P_WORDS(4), .P_STEP_UNIT_CYC(4)) dut_u (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_io_addr(io_addr), .i_io_rd_n(io_rd_n),
    .i_io_wr_n(io_wr_n), .i_io_data(io_wdata), .o_io_data(o_io_data), .o_io_data_oe_n(), .o_irq(o_irq),
    .i_drv_index(idx), .i_drv_ready(rdy), .i_drv_seek_done(seek_done_flag), .i_drv_track0(tk0),
    .i_drv_wfault(wf), .o_drv_step(), .o_drv_dir_in(), .o_drv_sel(), .o_drv_head(), .o_drv_wgate(o_drv_wgate),
    .i_dsk_id_ok(id_ok), .i_dsk_stb(i_dsk_stb), .i_dsk_word(i_dsk_word), .i_dsk_ecc_bad(ecc_bad),
    .i_dsk_ecc_fixed(ecc_fix), .o_dsk_word(o_dsk_word), .o_dsk_read(o_dsk_read), .o_dsk_write(o_dsk_write));

  dhti_host_model host_u (.i_core_clk(i_core_clk), .o_io_addr(io_addr), .o_io_rd_n(io_rd_n),
    .o_io_wr_n(io_wr_n), .o_io_data(io_wdata), .i_io_data(o_io_data));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic timeout(input string what);
    miscompares++;
    $display("unexpected at %0t: %s timed out", $time, what);
    complete_run();
  endtask : timeout

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    host_u.cycle(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [9:0] a);
    host_u.cycle(a, 1'b0, 16'h0000, q);
  endtask : rd

  // Polls the alternate port so no interrupt is consumed
  task automatic err_after_idle(input logic [15:0] mask, input logic [15:0] exp, input string what);
    rd(dhti_pkg::ADR_ASR);
    for (int n = 0; n < 300 && q[7] !== 1'b0; n++) rd(dhti_pkg::ADR_ASR);
    if (q[7] !== 1'b0) timeout(what);
    rd(dhti_pkg::ADR_ERR);
    cmp(q & mask, exp, what);
  endtask : err_after_idle

  task automatic wait_irq();
    for (int n = 0; n < 12000; n++) begin
      @(posedge i_core_clk);
      if (o_irq === 1'b1) return;
    end
    timeout("interrupt");
  endtask : wait_irq

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  initial begin
    {idx, i_dsk_stb, rdy, i_resetn} = 4'h2;
    {seek_done_flag, tk0, wf, id_ok, ecc_bad, ecc_fix} = 6'h24;
    i_dsk_word = 16'h0000;
    q = $urandom(32'h1005703E);
    repeat (3) @(posedge i_core_clk);
    #2 i_resetn = 1'b1;
    cmp({15'h0000, o_irq}, 16'h0000, "irq at reset");
    rd(dhti_pkg::ADR_DLM);
    cmp(q & 16'h007F, 16'h007F, "line monitor");
    for (int i = 0; i < 4; i++) begin
      #2 idx = 1'($urandom);
      rd(dhti_pkg::ADR_ASR);
      cmp(16'(q[1]), 16'(idx), "index");
      cmp(16'(q[6]), 16'h0001, "ready");
    end
    $display("done status");
    wr(dhti_pkg::ADR_ASR, 16'h0000);
    wr(dhti_pkg::ADR_CMD, 16'h0000);
    err_after_idle(16'h0004, 16'h0004, "bad code");
    wr(dhti_pkg::ADR_CMD, 16'h0090);
    err_after_idle(16'h00FF, {8'h00, dhti_pkg::DIAG_PASS}, "diagnose");
    wr(dhti_pkg::ADR_CYLL, 16'h0003);
    wr(dhti_pkg::ADR_CMD, 16'h007F);
    cmp({15'h0000, o_irq}, 16'h0000, "irq on command");
    wait_irq();
    $display("done commands");
    wr(dhti_pkg::ADR_SCNT, 16'h0001);
    wr(dhti_pkg::ADR_CMD, 16'h0030);
    rd(dhti_pkg::ADR_ASR);
    cmp(q & 16'h0088, 16'h0008, "write drq");
    cmp({15'h0000, o_irq}, 16'h0000, "no first irq");
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(int'($urandom & 32'hFFFF));
      wr(dhti_pkg::ADR_DATA, 16'(exp_q[$]));
    end
    for (int n = 0; n < 3000 && o_dsk_write !== 1'b1; n++) @(posedge i_core_clk);
    if (o_dsk_write !== 1'b1) timeout("write phase");
    for (int i = 0; i < 4; i++) begin
      #2 cmp(o_dsk_word, 16'(exp_q.pop_front()), "disk word");
      if (i > 0) cmp({15'h0000, o_drv_wgate}, 16'h0001, "write gate");
      i_dsk_stb = 1'b1;
      @(posedge i_core_clk);
    end
    #2 i_dsk_stb = 1'b0;
    wait_irq();
    $display("done write");
    wr(dhti_pkg::ADR_CMD, 16'h0020);
    for (int n = 0; n < 3000 && o_dsk_read !== 1'b1; n++) @(posedge i_core_clk);
    if (o_dsk_read !== 1'b1) timeout("disk phase");
    for (int i = 0; i < 4; i++) begin
      #2 {i_dsk_stb, ecc_bad, ecc_fix} = 3'h7;
      exp_q.push_back(int'($urandom & 32'hFFFF));
      i_dsk_word = 16'(exp_q[$]);
      @(posedge i_core_clk);
    end
    #2 {i_dsk_stb, ecc_bad, ecc_fix} = 3'h0;
    i_dsk_word = ~i_dsk_word;
    wait_irq();
    wr(dhti_pkg::ADR_ASR, 16'h0002);
    cmp({15'h0000, o_irq}, 16'h0000, "masked");
    wr(dhti_pkg::ADR_ASR, 16'h0000);
    cmp({15'h0000, o_irq}, 16'h0001, "pending kept");
    while (exp_q.size() > 0) begin
      rd(dhti_pkg::ADR_DATA);
      cmp(q, 16'(exp_q.pop_front()), "data word");
    end
    rd(dhti_pkg::ADR_ASR);
    cmp(q & 16'h0005, 16'h0004, "corrected");
    $display("done read");
    #2 id_ok = 1'b0;
    wr(dhti_pkg::ADR_CMD, 16'h0011);
    wait_irq();
    rd(dhti_pkg::ADR_ERR);
    cmp(q & 16'h0002, 16'h0002, "track zero limit");
    #2 tk0 = 1'b1;
    wr(dhti_pkg::ADR_CMD, 16'h0011);
    err_after_idle(16'h0002, 16'h0000, "track zero found");
    $display("done restore");
    wr(dhti_pkg::ADR_ASR, 16'h0004);
    repeat (260) @(posedge i_core_clk);
    wr(dhti_pkg::ADR_ASR, 16'h0000);
    cmp({15'h0000, o_irq}, 16'h0000, "soft reset");
    #2 rdy = 1'b0;
    wr(dhti_pkg::ADR_CMD, 16'h0020);
    err_after_idle(16'h0004, 16'h0004, "not ready");
    #2 {rdy, seek_done_flag} = 2'b10;
    wr(dhti_pkg::ADR_CMD, 16'h0020);
    err_after_idle(16'h0004, 16'h0004, "no seek done");
    #2 {seek_done_flag, wf} = 2'b11;
    wr(dhti_pkg::ADR_CMD, 16'h0030);
    err_after_idle(16'h0004, 16'h0004, "write fault");
    rd(dhti_pkg::ADR_ASR);
    cmp(q & 16'h0020, 16'h0020, "write fault flag");
    $display("done faults");
    complete_run();
  end
endmodule : dhti_core_bench
